/* verilog/ras_params.svh */
// constants of the reversing actuator starter
// assumes a 100 MHz system clock and a 1 ms switchover time base
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH

// clock and time base
`define RAS_CLK_PERIOD_NS 10
`define RAS_TICK_NS 1000000

// fieldbus control word bits
`define RAS_FB_LOCAL_BIT 9
`define RAS_FB_REMOTE_BIT 10

// register-bus coil numbers
`define RAS_COIL_LOCAL 8'h0a
`define RAS_COIL_REMOTE 8'h0b

// stop-mode enable bit positions
`define RAS_SM_LIMIT 0
`define RAS_SM_TORQUE 1
`define RAS_SM_OFF_LIMIT 2
`define RAS_SM_OFF_TORQUE 3
`define RAS_SM_OFF_CURRENT 4

// the six accepted stop-mode combinations
`define RAS_SM_CFG1 5'h05
`define RAS_SM_CFG2 5'h11
`define RAS_SM_CFG3 5'h07
`define RAS_SM_CFG4 5'h0b
`define RAS_SM_CFG5 5'h10
`define RAS_SM_CFG6 5'h0a

// reset values of the configuration and the current scale factor
`define RAS_RST_STOP_MODES 5'h05
`define RAS_RST_SW_TIME 16'h03e8
`define RAS_RST_THR4 8'h0a
`define RAS_THR4_SCALE 24'h00000a

`endif

/* verilog/ras_pkg.sv */
// types shared by the reversing actuator starter modules
// assumes nothing beyond a SystemVerilog compiler
package ras_pkg;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RIGHT = 2'b01,
        ST_LEFT = 2'b10,
        ST_SWITCH = 2'b11
    } ras_state_e;

    typedef enum logic [2:0] {
        SEL_FIELDBUS = 3'b000,
        SEL_REGBUS = 3'b001,
        SEL_HARDWIRE = 3'b010,
        SEL_FIX_LOCAL = 3'b011,
        SEL_FIX_REMOTE = 3'b100
    } ras_sel_e;

    typedef logic [4:0] ras_modes_t;

endpackage

/* verilog/ras_tmr_if.sv */
// link between the starter control and its switchover timer
// assumes both ends run on the system clock
`timescale 1ns/1ns
interface ras_tmr_if;
    logic restart;
    logic [15:0] sw_time;
    logic expired;

    modport ctrl (output restart, output sw_time, input expired);
    modport timer (input restart, input sw_time, output expired);
endinterface

/* verilog/ras_sync.sv */
// two-stage synchroniser for asynchronous field inputs
// assumes inputs are quasi-static levels from pins
`timescale 1ns/1ns
module ras_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // ras_sync

/* verilog/ras_timer.sv */
// prescaled direction-switchover timer
// assumes restart is a one-cycle pulse on the system clock
`timescale 1ns/1ns
`include "ras_params.svh"
module ras_timer #(
    parameter int TICK_CYCLES = `RAS_TICK_NS / `RAS_CLK_PERIOD_NS
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    ras_tmr_if.timer tmr
);
    logic [31:0] pre;
    logic tick;
    logic [15:0] left_ticks;

    // one-cycle time base, realigned on restart
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pre <= '0;
            tick <= 1'b0;
        end else if (tmr.restart || pre == 32'(TICK_CYCLES - 1)) begin
            pre <= '0;
            tick <= !tmr.restart;
        end else begin
            pre <= pre + 32'h1;
            tick <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            left_ticks <= '0;
            tmr.expired <= 1'b1;
        end else if (tmr.restart) begin
            left_ticks <= tmr.sw_time;
            tmr.expired <= (tmr.sw_time == 16'h0);
        end else if (tick && !tmr.expired) begin
            left_ticks <= left_ticks - 16'h1;
            tmr.expired <= (left_ticks <= 16'h1);
        end
    end
endmodule // ras_timer

/* verilog/ras_top.sv */
// reversing actuator starter: contactor control, selector, readiness
// assumes pins are asynchronous, remote and bus inputs are on clk_sys
`timescale 1ns/1ns
`include "ras_params.svh"
module ras_top #(
    parameter int TICK_CYCLES = `RAS_TICK_NS / `RAS_CLK_PERIOD_NS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // hardwired field pins, asynchronous
    input wire logic loc_run_right_cmd,
    input wire logic loc_run_left_cmd,
    input wire logic loc_stop_cmd,
    input wire logic off_input_ok,
    input wire logic drawer_sup_in,
    input wire logic mode_local_in,
    input wire logic mode_remote_in,
    input wire logic reset_alarm_in,
    input wire logic lim_right_n,
    input wire logic lim_left_n,
    // remote source commands, one-cycle pulses
    input wire logic rem_run_right_cmd,
    input wire logic rem_run_left_cmd,
    input wire logic rem_stop_cmd,
    // fieldbus and register-bus selector inputs
    input wire logic [15:0] fb_ctrl_word,
    input wire logic fb_clear,
    input wire logic coil_wr,
    input wire logic [7:0] coil_addr,
    input wire logic coil_val,
    input wire logic reg_clear,
    // fault events and current measurement
    input wire logic fault_event,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] motor_rated_current,
    // configuration write
    input wire logic off_input_mapped,
    input wire logic param_allowed,
    input wire logic cfg_wr,
    input wire logic [4:0] cfg_stop_modes,
    input wire logic [2:0] cfg_sel,
    input wire logic cfg_sup_en,
    input wire logic cfg_allow_switch,
    input wire logic [15:0] cfg_sw_time,
    input wire logic [7:0] cfg_thr4,
    // contactors and status
    output logic right_contactor,
    output logic left_contactor,
    output logic drawer_ready,
    output logic pos_switch_err,
    output logic fault_active,
    output logic local_active,
    output logic remote_active,
    output logic blocked_right,
    output logic blocked_left,
    output logic cfg_rejected,
    output logic [4:0] cur_stop_modes
);
    ras_tmr_if tmr ();

    logic [9:0] pins_s;
    logic loc_r_s, loc_l_s, loc_stop_s, off_ok_s, sup_s;
    logic mode_loc_s, mode_rem_s, rst_alarm_s, lim_r, lim_l;
    logic loc_r_d, loc_l_d, rst_alarm_d;

    ras_pkg::ras_state_e state, next_state;
    ras_pkg::ras_sel_e sel;
    logic [1:0] pend_dir;
    logic [1:0] last_dir;
    logic sup_en, allow_switch;
    logic [15:0] sw_time;
    logic [7:0] thr4;
    logic coil_loc, coil_rem;
    logic fault, pos_err;

    logic loc_sel, rem_sel, both_lim, ready_now, clear_any;
    logic req_r, req_l, req_stop;
    logic over_cur, end_r, end_l, can_r, can_l;
    logic [23:0] cur_scaled, thr_scaled;
    logic cfg_ok;

    ras_sync #(.W(10)) u_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .din({loc_run_right_cmd, loc_run_left_cmd, loc_stop_cmd,
              off_input_ok, drawer_sup_in, mode_local_in, mode_remote_in,
              reset_alarm_in, !lim_right_n, !lim_left_n}),
        .dout(pins_s)
    );
    assign {loc_r_s, loc_l_s, loc_stop_s, off_ok_s, sup_s, mode_loc_s,
            mode_rem_s, rst_alarm_s, lim_r, lim_l} = pins_s;

    ras_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .tmr(tmr)
    );

    // edge detection on the synchronised run and alarm-reset pin commands
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            loc_r_d <= 1'b0;
            loc_l_d <= 1'b0;
            rst_alarm_d <= 1'b0;
        end else begin
            loc_r_d <= loc_r_s;
            loc_l_d <= loc_l_s;
            rst_alarm_d <= rst_alarm_s;
        end
    end

    // selector: which class of sources holds run/stop authority
    always_comb begin
        case (sel)
            ras_pkg::SEL_FIELDBUS: begin
                loc_sel = fb_ctrl_word[`RAS_FB_LOCAL_BIT];
                rem_sel = fb_ctrl_word[`RAS_FB_REMOTE_BIT];
            end
            ras_pkg::SEL_REGBUS: begin
                loc_sel = coil_loc;
                rem_sel = coil_rem;
            end
            ras_pkg::SEL_HARDWIRE: begin
                loc_sel = mode_loc_s;
                rem_sel = mode_rem_s;
            end
            ras_pkg::SEL_FIX_LOCAL: begin
                loc_sel = 1'b1;
                rem_sel = 1'b0;
            end
            ras_pkg::SEL_FIX_REMOTE: begin
                loc_sel = 1'b0;
                rem_sel = 1'b1;
            end
            default: begin
                loc_sel = 1'b0;
                rem_sel = 1'b0;
            end
        endcase
    end

    // coil writes latch the register-bus selection
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            coil_loc <= 1'b0;
            coil_rem <= 1'b0;
        end else if (coil_wr) begin
            // selecting one class drops the other
            if (coil_addr == `RAS_COIL_LOCAL) begin
                coil_loc <= coil_val;
                coil_rem <= coil_rem && !coil_val;
            end
            if (coil_addr == `RAS_COIL_REMOTE) begin
                coil_rem <= coil_val;
                coil_loc <= coil_loc && !coil_val;
            end
        end
    end

    // configuration, taken only when permitted and a valid combination
    always_comb begin
        case (cfg_stop_modes)
            `RAS_SM_CFG1, `RAS_SM_CFG2, `RAS_SM_CFG3,
            `RAS_SM_CFG4, `RAS_SM_CFG5, `RAS_SM_CFG6: cfg_ok = 1'b1;
            default: cfg_ok = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cur_stop_modes <= `RAS_RST_STOP_MODES;
            sel <= ras_pkg::SEL_HARDWIRE;
            sup_en <= 1'b0;
            allow_switch <= 1'b0;
            sw_time <= `RAS_RST_SW_TIME;
            thr4 <= `RAS_RST_THR4;
            cfg_rejected <= 1'b0;
        end else begin
            cfg_rejected <= 1'b0;
            if (cfg_wr) begin
                if (param_allowed && cfg_ok) begin
                    cur_stop_modes <= cfg_stop_modes;
                    sel <= ras_pkg::ras_sel_e'(cfg_sel);
                    sup_en <= cfg_sup_en;
                    allow_switch <= cfg_allow_switch;
                    sw_time <= cfg_sw_time;
                    thr4 <= cfg_thr4;
                end else begin
                    cfg_rejected <= 1'b1;
                end
            end
        end
    end

    // faults and position-switch error: a new event wins over a clear
    assign both_lim = lim_r && lim_l;
    assign clear_any = (rst_alarm_s && !rst_alarm_d) || reg_clear
                       || fb_clear;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fault <= 1'b0;
            pos_err <= 1'b0;
        end else begin
            if (fault_event) begin
                fault <= 1'b1;
            end else if (clear_any) begin
                fault <= 1'b0;
            end
            if (both_lim) begin
                pos_err <= 1'b1;
            end else if (clear_any) begin
                pos_err <= 1'b0;
            end
        end
    end

    // drawer-ready condition
    assign ready_now = !fault && !pos_err
                       && off_input_mapped && off_ok_s
                       && (!sup_en || sup_s)
                       && !(loc_sel && rem_sel);

    // commands from sources that hold authority; stop also whenever the off input is not ok
    assign req_r = (loc_sel && loc_r_s && !loc_r_d)
                   || (rem_sel && rem_run_right_cmd);
    assign req_l = (loc_sel && loc_l_s && !loc_l_d)
                   || (rem_sel && rem_run_left_cmd);
    assign req_stop = (loc_sel && loc_stop_s) || (rem_sel && rem_stop_cmd)
                      || !off_ok_s;

    // current threshold as a multiple of rated current, in tenths
    assign cur_scaled = 24'(motor_current) * `RAS_THR4_SCALE;
    assign thr_scaled = 24'(motor_rated_current) * 24'(thr4);
    assign over_cur = cur_scaled > thr_scaled;

    // end-of-travel stop for the running direction
    always_comb begin
        end_r = 1'b0;
        end_l = 1'b0;
        if (cur_stop_modes[`RAS_SM_OFF_LIMIT]) begin
            end_r = lim_r;
            end_l = lim_l;
        end else if (cur_stop_modes[`RAS_SM_OFF_CURRENT]) begin
            if (cur_stop_modes[`RAS_SM_LIMIT]) begin
                end_r = lim_r && over_cur;
                end_l = lim_l && over_cur;
            end else begin
                end_r = over_cur;
                end_l = over_cur;
            end
        end
    end

    // start permission per direction
    assign can_r = drawer_ready && !both_lim && !blocked_right
                   && (last_dir != 2'b10 || tmr.expired);
    assign can_l = drawer_ready && !both_lim && !blocked_left
                   && (last_dir != 2'b01 || tmr.expired);

    always_comb begin
        next_state = state;
        case (state)
            ras_pkg::ST_OFF: begin
                if (req_stop) begin
                    next_state = ras_pkg::ST_OFF;
                end else if (req_r && can_r) begin
                    next_state = ras_pkg::ST_RIGHT;
                end else if (req_l && can_l) begin
                    next_state = ras_pkg::ST_LEFT;
                end
            end
            ras_pkg::ST_RIGHT: begin
                if (req_stop || !ready_now || end_r) begin
                    next_state = ras_pkg::ST_OFF;
                end else if (req_l && allow_switch) begin
                    next_state = ras_pkg::ST_SWITCH;
                end
            end
            ras_pkg::ST_LEFT: begin
                if (req_stop || !ready_now || end_l) begin
                    next_state = ras_pkg::ST_OFF;
                end else if (req_r && allow_switch) begin
                    next_state = ras_pkg::ST_SWITCH;
                end
            end
            ras_pkg::ST_SWITCH: begin
                if (req_stop) begin
                    next_state = ras_pkg::ST_OFF;
                end else if (tmr.expired) begin
                    if (pend_dir == 2'b01 && can_r) begin
                        next_state = ras_pkg::ST_RIGHT;
                    end else if (pend_dir == 2'b10 && can_l) begin
                        next_state = ras_pkg::ST_LEFT;
                    end else begin
                        next_state = ras_pkg::ST_OFF;
                    end
                end
            end
            default: next_state = ras_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= ras_pkg::ST_OFF;
            pend_dir <= 2'b00;
            last_dir <= 2'b00;
        end else begin
            state <= next_state;
            if (next_state == ras_pkg::ST_SWITCH
                && state != ras_pkg::ST_SWITCH) begin
                pend_dir <= (state == ras_pkg::ST_RIGHT) ? 2'b10 : 2'b01;
            end
            if (next_state == ras_pkg::ST_RIGHT) begin
                last_dir <= 2'b01;
            end else if (next_state == ras_pkg::ST_LEFT) begin
                last_dir <= 2'b10;
            end
        end
    end

    // contactors follow the state; the switch state holds both open
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            right_contactor <= 1'b0;
            left_contactor <= 1'b0;
        end else begin
            right_contactor <= (next_state == ras_pkg::ST_RIGHT);
            left_contactor <= (next_state == ras_pkg::ST_LEFT);
        end
    end

    // timer restarts on the cycle a contactor opens
    assign tmr.restart = (right_contactor
                          && next_state != ras_pkg::ST_RIGHT)
                         || (left_contactor
                          && next_state != ras_pkg::ST_LEFT);
    assign tmr.sw_time = sw_time;

    // same-direction block after an end-of-travel stop
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            blocked_right <= 1'b0;
            blocked_left <= 1'b0;
        end else begin
            if (state == ras_pkg::ST_RIGHT && end_r && !req_stop) begin
                blocked_right <= 1'b1;
            end else if (next_state == ras_pkg::ST_LEFT) begin
                blocked_right <= 1'b0;
            end
            if (state == ras_pkg::ST_LEFT && end_l && !req_stop) begin
                blocked_left <= 1'b1;
            end else if (next_state == ras_pkg::ST_RIGHT) begin
                blocked_left <= 1'b0;
            end
        end
    end

    // registered status
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drawer_ready <= 1'b0;
            pos_switch_err <= 1'b0;
            fault_active <= 1'b0;
            local_active <= 1'b0;
            remote_active <= 1'b0;
        end else begin
            drawer_ready <= ready_now;
            pos_switch_err <= pos_err;
            fault_active <= fault;
            local_active <= loc_sel;
            remote_active <= rem_sel;
        end
    end
endmodule // ras_top

/* bench/ras_field_model.sv */
// field side of the starter: valve travel, end switches, motor current
// assumes contactor levels from ras_top on the same clock
`timescale 1ns/1ns
module ras_field_model #(
    parameter int TRAVEL = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // contactors and a wiring fault forcing both end switches
    input wire logic right_contactor,
    input wire logic left_contactor,
    input wire logic both_lim,
    // field feedback
    output logic lim_right_n,
    output logic lim_left_n,
    output logic [15:0] motor_current
);
    int pos;

    // valve travel, clamped at both ends
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pos <= TRAVEL / 2;
        end else if (right_contactor && pos < TRAVEL) begin
            pos <= pos + 1;
        end else if (left_contactor && pos > 0) begin
            pos <= pos - 1;
        end
    end

    assign lim_right_n = !(both_lim || pos == TRAVEL);
    assign lim_left_n = !(both_lim || pos == 0);
    // motor stalls and draws twice rated current against an end stop
    assign motor_current = ((right_contactor && pos == TRAVEL) ||
        (left_contactor && pos == 0)) ? 16'h00c8 :
        (right_contactor || left_contactor) ? 16'h0032 : 16'h0000;
endmodule // ras_field_model

/* bench/ras_top_checker.sv */
// assertions on the ports of the starter top
// assumes one clock domain and asynchronous active-low reset
`timescale 1ns/1ns
module ras_top_checker #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // inputs watched
    input wire logic lim_right_n,
    input wire logic lim_left_n,
    input wire logic rem_stop_cmd,
    input wire logic cfg_wr,
    input wire logic param_allowed,
    input wire logic [4:0] cfg_stop_modes,
    // outputs watched
    input wire logic right_contactor,
    input wire logic left_contactor,
    input wire logic drawer_ready,
    input wire logic pos_switch_err,
    input wire logic fault_active,
    input wire logic local_active,
    input wire logic remote_active,
    input wire logic cfg_rejected,
    input wire logic [4:0] cur_stop_modes
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    a_never_both: assert property (
        !(right_contactor && left_contactor))
        else $error("both contactors closed");
    a_right_ready: assert property ($rose(right_contactor) |->
        $past(drawer_ready)) else $error("right start without ready");
    a_left_ready: assert property ($rose(left_contactor) |->
        $past(drawer_ready)) else $error("left start without ready");
    a_both_lim_err: assert property ((!lim_right_n && !lim_left_n)[*5]
        |-> pos_switch_err) else $error("no position switch error");
    a_both_lim_start: assert property (
        (!lim_right_n && !lim_left_n)[*4]
        |=> !$rose(right_contactor) && !$rose(left_contactor))
        else $error("start with both limits");
    a_stop_opens: assert property (rem_stop_cmd && remote_active |=>
        !right_contactor && !left_contactor) else $error("stop ignored");
    a_cfg_locked: assert property (cfg_wr && !param_allowed |=>
        cfg_rejected && $stable(cur_stop_modes))
        else $error("locked config changed");
    a_bad_modes: assert property (cfg_wr && !(cfg_stop_modes inside
        {5'h05, 5'h11, 5'h07, 5'h0b, 5'h10, 5'h0a}) |=> cfg_rejected)
        else $error("bad stop modes taken");
    a_fault_ready: assert property (fault_active && $past(fault_active)
        |-> !drawer_ready) else $error("ready during fault");
    a_dual_sel: assert property (local_active && remote_active &&
        $past(local_active && remote_active) |-> !drawer_ready)
        else $error("ready with both selections");
    a_switch_gap: assert property ($fell(right_contactor) |->
        (!left_contactor)[*4]) else $error("opposite closed too soon");
endmodule // ras_top_checker

bind ras_top ras_top_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);

/* bench/ras_bench.sv */
// self-checking bench for the reversing actuator starter
// assumes ras_top with a 4-cycle tick and the field model
`timescale 1ns/1ns
module ras_bench;
    logic clk_sys = 1'h0;
    logic arst_n, loc_run_right_cmd, loc_run_left_cmd, loc_stop_cmd;
    logic off_input_ok, drawer_sup_in, mode_local_in, mode_remote_in;
    logic reset_alarm_in, lim_right_n, lim_left_n, rem_run_right_cmd;
    logic rem_run_left_cmd, rem_stop_cmd, fb_clear, coil_wr, coil_val;
    logic reg_clear, fault_event, off_input_mapped, param_allowed, cfg_wr;
    logic cfg_sup_en, cfg_allow_switch, both_lim, right_contactor;
    logic left_contactor, drawer_ready, pos_switch_err, fault_active;
    logic local_active, remote_active, blocked_right, blocked_left;
    logic cfg_rejected;
    logic [15:0] fb_ctrl_word, motor_current, motor_rated_current;
    logic [15:0] cfg_sw_time;
    logic [7:0] coil_addr, cfg_thr4;
    logic [4:0] cfg_stop_modes, cur_stop_modes;
    logic [2:0] cfg_sel;
    logic [4:0] good_modes [6] = '{5'h05, 5'h11, 5'h07, 5'h0b, 5'h10, 5'h0a};
    int miscompares = 0;
    int checks_done = 0;

    ras_top #(.TICK_CYCLES(4)) u_dut (.*);
    ras_field_model u_field (.*);

    always #5 clk_sys = ~clk_sys;

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // remote pulse, bits are right, left, stop
    task automatic rem(input logic [2:0] v);
        {rem_run_right_cmd, rem_run_left_cmd, rem_stop_cmd} = v;
        tick(1);
        {rem_run_right_cmd, rem_run_left_cmd, rem_stop_cmd} = 3'h0;
    endtask

    task automatic cfg(input logic [4:0] m, input logic [2:0] s,
        input logic a);
        {cfg_stop_modes, cfg_sel, cfg_allow_switch, cfg_wr} = {m, s, a, 1'h1};
        tick(1);
        cfg_wr = 1'h0;
    endtask

    task automatic sel(input logic [2:0] s, input logic [15:0] w,
        input logic [1:0] hw, input logic [7:0] ca, input logic el, er);
        cfg(5'h05, s, 1'h0);
        {fb_ctrl_word, mode_local_in, mode_remote_in} = {w, hw};
        {coil_addr, coil_wr} = {ca, ca != 8'h00};
        tick(1);
        coil_wr = 1'h0;
        tick(4);
        chk("local_active", el, local_active);
        chk("remote_active", er, remote_active);
    endtask

    // bound well above the roughly 270 cycles the sequence needs
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end

    initial begin
        {arst_n, loc_run_right_cmd, loc_run_left_cmd, loc_stop_cmd,
            drawer_sup_in, mode_local_in, reset_alarm_in, rem_run_right_cmd,
            rem_run_left_cmd, rem_stop_cmd, fb_clear, coil_wr, reg_clear,
            fault_event, cfg_wr, cfg_sup_en, cfg_allow_switch, both_lim} = '0;
        {off_input_ok, off_input_mapped, param_allowed, mode_remote_in,
            coil_val} = '1;
        {fb_ctrl_word, coil_addr, cfg_thr4} = {16'h0000, 8'h00, 8'h0a};
        {cfg_stop_modes, cfg_sel} = {5'h05, 3'h2};
        {motor_rated_current, cfg_sw_time} = {16'h0064, 16'h0002};
        tick(10);
        arst_n = 1'h1;
        tick(6);
        chk("ready", 1'h1, drawer_ready);
        chk("modes", 5'h05, cur_stop_modes);
        cfg(5'h05, 3'h2, 1'h0);
        off_input_ok = 1'h0;
        tick(4);
        chk("ready", 1'h0, drawer_ready);
        rem(3'h4);
        chk("right", 1'h0, right_contactor);
        off_input_ok = 1'h1;
        tick(4);
        rem(3'h4);
        chk("right", 1'h1, right_contactor);
        rem(3'h2);
        chk("right", 1'h1, right_contactor);
        cfg(5'h05, 3'h2, 1'h1);
        rem(3'h2);
        chk("right", 1'h0, right_contactor);
        tick(3);
        chk("left", 1'h0, left_contactor);
        tick(10);
        chk("left", 1'h1, left_contactor);
        rem(3'h1);
        chk("left", 1'h0, left_contactor);
        tick(12);
        rem(3'h4);
        tick(13);
        chk("blk_right", 1'h1, blocked_right);
        rem(3'h4);
        chk("right", 1'h0, right_contactor);
        rem(3'h2);
        chk("left", 1'h0, left_contactor);
        tick(12);
        rem(3'h2);
        chk("left", 1'h1, left_contactor);
        tick(24);
        chk("blk_left", 1'h1, blocked_left);
        cfg(5'h11, 3'h2, 1'h0);
        tick(6);
        rem(3'h4);
        tick(24);
        rem(3'h4);
        chk("right", 1'h0, right_contactor);
        chk("blk_right", 1'h1, blocked_right);
        foreach (good_modes[i]) begin
            cfg(good_modes[i], 3'h2, 1'h0);
            chk("modes", good_modes[i], cur_stop_modes);
        end
        cfg(5'h03, 3'h2, 1'h0);
        chk("reject", 1'h1, cfg_rejected);
        param_allowed = 1'h0;
        cfg(5'h05, 3'h2, 1'h0);
        chk("modes", 5'h0a, cur_stop_modes);
        param_allowed = 1'h1;
        sel(3'h0, 16'h0200, 2'h0, 8'h00, 1'h1, 1'h0);
        sel(3'h0, 16'h0400, 2'h0, 8'h00, 1'h0, 1'h1);
        sel(3'h1, 16'h0000, 2'h0, 8'h0a, 1'h1, 1'h0);
        sel(3'h1, 16'h0000, 2'h0, 8'h0b, 1'h0, 1'h1);
        sel(3'h1, 16'h0000, 2'h0, 8'h0c, 1'h0, 1'h1);
        sel(3'h2, 16'h0000, 2'h2, 8'h00, 1'h1, 1'h0);
        mode_remote_in = 1'h1;
        tick(5);
        chk("ready", 1'h0, drawer_ready);
        sel(3'h3, 16'h0000, 2'h0, 8'h00, 1'h1, 1'h0);
        loc_run_left_cmd = 1'h1;
        tick(6);
        chk("left", 1'h1, left_contactor);
        loc_stop_cmd = 1'h1;
        tick(5);
        chk("left", 1'h0, left_contactor);
        {loc_run_left_cmd, loc_stop_cmd} = 2'h0;
        sel(3'h4, 16'h0000, 2'h0, 8'h00, 1'h0, 1'h1);
        loc_run_left_cmd = 1'h1;
        tick(6);
        chk("left", 1'h0, left_contactor);
        {cfg_sup_en, loc_run_left_cmd} = 2'h2;
        cfg(5'h05, 3'h4, 1'h0);
        tick(4);
        chk("ready", 1'h0, drawer_ready);
        drawer_sup_in = 1'h1;
        tick(4);
        chk("ready", 1'h1, drawer_ready);
        for (int i = 0; i < 3; i++) begin
            fault_event = 1'h1;
            tick(1);
            fault_event = 1'h0;
            tick(2);
            chk("ready", 1'h0, drawer_ready);
            {reset_alarm_in, fb_clear, reg_clear} = 3'h4 >> i;
            tick(4);
            {reset_alarm_in, fb_clear, reg_clear} = 3'h0;
            tick(3);
            chk("ready", 1'h1, drawer_ready);
        end
        both_lim = 1'h1;
        tick(5);
        chk("pos_err", 1'h1, pos_switch_err);
        rem(3'h4);
        chk("right", 1'h0, right_contactor);
        wrap_up();
    end
endmodule // ras_bench
